// [design/spm_crc8.sv]
/*
 * Bit-serial CRC-8 generator over every bit seen on the wire.
 * Assumes the controller clears it before the first bit of a code.
 */
`timescale 1ns/10ps
`include "spm_map.svh"
module spm_crc8
    import spm_pkg::*;
(
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_b,
    // Bit stream and result
    spm_crc_if.sink     crc_io
);
    logic [7:0] crc_ff;
    logic       fb;

    assign fb         = crc_ff[0] ^ crc_io.bit_in;
    assign crc_io.crc = crc_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_ff <= `SPM_CRC_INIT;
        end else if (crc_io.clr) begin
            crc_ff <= `SPM_CRC_INIT; // [RL4]
        end else if (crc_io.shift) begin
            // Residue of zero after the CRC bits means a clean code
            crc_ff <= {1'b0, crc_ff[7:1]} ^ (fb ? `SPM_CRC_POLY : 8'h00); // [RL4] [RL5] [RL6]
        end
    end
endmodule // spm_crc8

// [design/spm_crc_if.sv]
/*
 * Carrier between the controller and its CRC generator.
 * Assumes one clock domain; the controller drives, the generator sinks.
 */
`timescale 1ns/10ps
interface spm_crc_if;
    logic       clr;
    logic       shift;
    logic       bit_in;
    logic [7:0] crc;

    modport source (output clr, output shift, output bit_in, input crc);
    modport sink   (input clr, input shift, input bit_in, output crc);
endinterface // spm_crc_if

// [design/spm_ctrl.sv]
/*
 * Single-wire bus master for the scratchpad memory tag: reset/presence,
 * byte slots, CRC and tracking of the command sequence, under Wishbone.
 * Assumes an external pull-up on the wire and a 100 MHz sys_clk.
 */
`timescale 1ns/10ps
`include "spm_map.svh"
module spm_ctrl
    import spm_pkg::*;
#(
    parameter logic [`SPM_CNT_W-1:0] P_RST_LOW  = `SPM_CNT_W'(`SPM_CNT_RST_LOW),
    parameter logic [`SPM_CNT_W-1:0] P_PRES_SMP = `SPM_CNT_W'(`SPM_CNT_PRES_SMP),
    parameter logic [`SPM_CNT_W-1:0] P_RST_END  = `SPM_CNT_W'(`SPM_CNT_RST_END),
    parameter logic [`SPM_CNT_W-1:0] P_SLOT     = `SPM_CNT_W'(`SPM_CNT_SLOT),
    parameter logic [`SPM_CNT_W-1:0] P_LOW1     = `SPM_CNT_W'(`SPM_CNT_LOW1),
    parameter logic [`SPM_CNT_W-1:0] P_LOW0     = `SPM_CNT_W'(`SPM_CNT_LOW0),
    parameter logic [`SPM_CNT_W-1:0] P_SMP      = `SPM_CNT_W'(`SPM_CNT_SMP)
)(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Single data wire, open drain
    input  wire logic        dq_in,
    output logic             dq_out,
    output logic             dq_oe_b
);
    spm_wire_e              wire_ff;
    spm_phase_e             phase_ff;
    logic [`SPM_CNT_W-1:0]  cnt_ff;
    logic [2:0]             bit_ff;
    spm_byte_t              shift_ff;
    spm_byte_t              txd_ff;
    spm_byte_t              rxd_ff;
    spm_byte_t              cmd_ff;
    logic [1:0]             idx_ff;
    spm_byte_t              ta_low_ff;
    spm_byte_t              ta_high_ff;
    spm_byte_t              es_ff;
    logic                   presence_ff;
    logic                   refused_ff;
    logic                   auth_bad_ff;
    logic                   ack_ff;
    logic [31:0]            rdat_ff;
    logic                   acc;
    logic                   wr;
    logic                   go_reset;
    logic                   go_byte;
    logic                   start_ok;
    logic                   slot_end;
    logic                   byte_done;
    logic                   rst_done;
    logic                   smp;
    logic                   cur_bit;
    logic                   smp_bit_ff;
    spm_byte_t              done_byte;
    spm_crc_if              crc_io ();

    // Register hit on a new access; address decode shared by read and write
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction

    assign acc      = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr       = acc & wb_we_i & wb_sel_i[0];
    assign go_reset = wr & hit(wb_adr_i, `SPM_ADR_CTRL) & wb_dat_i[`SPM_CTRL_RESET];
    assign go_byte  = wr & hit(wb_adr_i, `SPM_ADR_CTRL)
                    & (wb_dat_i[`SPM_CTRL_TX] | wb_dat_i[`SPM_CTRL_RX]);
    // No slot before a reset with presence has opened a sequence
    assign start_ok = (wire_ff == SPM_WIRE_IDLE) & (phase_ff != SPM_PH_NONE); // [RL2]
    assign cur_bit  = shift_ff[0];
    assign slot_end = (wire_ff == SPM_WIRE_SLOT) & (cnt_ff == P_SLOT - 1'b1);
    assign byte_done = slot_end & (bit_ff == 3'd7);
    assign rst_done = (wire_ff == SPM_WIRE_RESET) & (cnt_ff == P_RST_END - 1'b1);
    assign smp      = (wire_ff == SPM_WIRE_SLOT) & (cnt_ff == P_SMP);
    assign done_byte = {smp_bit_ff, shift_ff[7:1]};

    assign crc_io.clr    = wr & hit(wb_adr_i, `SPM_ADR_CTRL) & wb_dat_i[`SPM_CTRL_CRC_CLR];
    assign crc_io.shift  = smp;
    assign crc_io.bit_in = dq_in;

    spm_crc8 u_crc (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .crc_io  (crc_io)
    );

    // Wishbone answer one cycle after the request
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdat_ff <= 32'h0000_0000;
        end else if (acc & ~wb_we_i) begin
            unique case (1'b1)
                hit(wb_adr_i, `SPM_ADR_TXD):     rdat_ff <= {24'h00_0000, txd_ff};
                hit(wb_adr_i, `SPM_ADR_RXD):     rdat_ff <= {24'h00_0000, rxd_ff};
                hit(wb_adr_i, `SPM_ADR_STAT):    rdat_ff <= {26'h000_0000, auth_bad_ff,
                    refused_ff, crc_io.crc == 8'h00, phase_ff == SPM_PH_MEM
                    || phase_ff == SPM_PH_DATA, presence_ff, wire_ff != SPM_WIRE_IDLE};
                hit(wb_adr_i, `SPM_ADR_CRC):     rdat_ff <= {24'h00_0000, crc_io.crc};
                hit(wb_adr_i, `SPM_ADR_TA_LOW):  rdat_ff <= {24'h00_0000, ta_low_ff};
                hit(wb_adr_i, `SPM_ADR_TA_HIGH): rdat_ff <= {24'h00_0000, ta_high_ff};
                hit(wb_adr_i, `SPM_ADR_ES):      rdat_ff <= {24'h00_0000, es_ff};
                default:                         rdat_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            txd_ff <= 8'h00;
        end else if (wr & hit(wb_adr_i, `SPM_ADR_TXD)) begin
            txd_ff <= wb_dat_i[7:0];
        end
    end

    // Wire timing: one counter serves both reset and bit slots
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wire_ff <= SPM_WIRE_IDLE;
            cnt_ff  <= '0;
            bit_ff  <= 3'd0;
        end else begin
            unique case (wire_ff)
                SPM_WIRE_IDLE: begin
                    cnt_ff <= '0;
                    bit_ff <= 3'd0;
                    if (go_reset) begin
                        wire_ff <= SPM_WIRE_RESET;
                    end else if (go_byte & start_ok) begin
                        wire_ff <= SPM_WIRE_SLOT;
                    end
                end
                SPM_WIRE_RESET: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (rst_done) begin
                        wire_ff <= SPM_WIRE_IDLE;
                    end
                end
                SPM_WIRE_SLOT: begin
                    cnt_ff <= slot_end ? '0 : cnt_ff + 1'b1;
                    if (slot_end) begin
                        bit_ff <= bit_ff + 3'd1;
                        if (byte_done) begin
                            wire_ff <= SPM_WIRE_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Pull low only for the reset pulse and the active part of each slot; the pull-up does the rest
    assign dq_out = 1'b0;
    always_comb begin
        dq_oe_b = 1'b1;
        if (wire_ff == SPM_WIRE_RESET) begin
            dq_oe_b = ~(cnt_ff < P_RST_LOW);
        end else if (wire_ff == SPM_WIRE_SLOT) begin
            dq_oe_b = ~(cnt_ff < (cur_bit ? P_LOW1 : P_LOW0));
        end
    end

    // Shift out LSB first; the sampled wire fills from the top
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= 8'h00;
            rxd_ff   <= 8'h00;
        end else if (wire_ff == SPM_WIRE_IDLE & go_byte & start_ok) begin
            // A read is a byte of ones, so the device may pull any bit low
            shift_ff <= wb_dat_i[`SPM_CTRL_TX] ? txd_ff : `SPM_RX_FILL; // [RL1]
        end else if (slot_end) begin
            shift_ff <= done_byte; // [RL1]
            if (byte_done) begin
                rxd_ff <= done_byte;
            end
        end
    end

    // Level at P_SMP into the slot, well before its middle; a device's zero may be gone by slot end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            smp_bit_ff <= 1'b1;
        end else if (smp) begin
            smp_bit_ff <= dq_in; // [RL1]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            presence_ff <= 1'b0;
        end else if (go_reset & wire_ff == SPM_WIRE_IDLE) begin
            presence_ff <= 1'b0;
        end else if (wire_ff == SPM_WIRE_RESET & cnt_ff == P_PRES_SMP) begin
            presence_ff <= ~dq_in;
        end
    end

    // Sequence tracking: reset, ROM selection, memory command, data
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= SPM_PH_NONE;
            cmd_ff   <= 8'h00;
            idx_ff   <= 2'd0;
        end else if (rst_done) begin
            phase_ff <= presence_ff ? SPM_PH_ROM : SPM_PH_NONE;
        end else if (wr & hit(wb_adr_i, `SPM_ADR_CTRL) & wb_dat_i[`SPM_CTRL_ROM_DONE]
                     & phase_ff == SPM_PH_ROMDATA) begin
            phase_ff <= SPM_PH_MEM; // [RL2]
        end else if (byte_done) begin
            unique case (phase_ff)
                SPM_PH_ROM: begin
                    phase_ff <= (done_byte == `SPM_ROM_SKIP) ? SPM_PH_MEM : SPM_PH_ROMDATA;
                end
                SPM_PH_MEM: begin
                    phase_ff <= SPM_PH_DATA;
                    cmd_ff   <= done_byte;
                    idx_ff   <= 2'd0;
                end
                SPM_PH_DATA: begin
                    idx_ff <= (idx_ff == 2'd3) ? idx_ff : idx_ff + 2'd1;
                end
                default: begin
                    phase_ff <= phase_ff;
                end
            endcase
        end
    end

    // Shadow of the device's address registers, learned from traffic
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ta_low_ff  <= 8'h00;
            ta_high_ff <= 8'h00;
            es_ff      <= 8'h00;
        end else if (byte_done & phase_ff == SPM_PH_MEM & done_byte == `SPM_CMD_WR_SP) begin
            // Flags restart with each write; authorization drops too
            es_ff[`SPM_ES_AA_BIT:`SPM_ES_PF_BIT] <= 3'b000; // [RL18] [RL20]
        end else if (byte_done & phase_ff == SPM_PH_DATA & idx_ff != 2'd3) begin
            if (cmd_ff == `SPM_CMD_WR_SP | cmd_ff == `SPM_CMD_RD_MEM
                | cmd_ff == `SPM_CMD_RD_SP) begin
                if (idx_ff == 2'd0) begin
                    ta_low_ff <= done_byte; // [RL12] [RL16] [RL19]
                end
                if (idx_ff == 2'd1) begin
                    ta_high_ff <= done_byte; // [RL12] [RL16] [RL19]
                end
                if (idx_ff == 2'd2 & cmd_ff == `SPM_CMD_RD_SP) begin
                    es_ff <= done_byte; // [RL16]
                end
            end
        end
    end

    // Sticky error flags; a new error wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            refused_ff  <= 1'b0;
            auth_bad_ff <= 1'b0;
        end else begin
            if (go_byte & ~start_ok) begin
                refused_ff <= 1'b1; // [RL2]
            end else if (wr & hit(wb_adr_i, `SPM_ADR_STAT) & wb_dat_i[`SPM_ST_REFUSED]) begin
                refused_ff <= 1'b0;
            end
            if (byte_done & phase_ff == SPM_PH_DATA & cmd_ff == `SPM_CMD_COPY
                & idx_ff != 2'd3
                & done_byte != (idx_ff == 2'd0 ? ta_low_ff :
                                idx_ff == 2'd1 ? ta_high_ff : es_ff)) begin
                auth_bad_ff <= 1'b1; // [RL17]
            end else if (wr & hit(wb_adr_i, `SPM_ADR_STAT) & wb_dat_i[`SPM_ST_AUTH_BAD]) begin
                auth_bad_ff <= 1'b0;
            end
        end
    end
endmodule // spm_ctrl

// [design/spm_map.svh]
/*
 * Register offsets, field positions, command codes and slot timing for the
 * single-wire scratchpad memory controller.
 * Assumes a 100 MHz sys_clk and one open-drain data wire with a pull-up.
 */
// Notes on behaviour
// RL1: Bytes move on the wire LSB first.
// RL2: Memory commands only after a ROM selection sequence.
// RL3: Identity is family, serial number, then CRC.
// RL4: CRC-8 x^8+x^5+x^4+1, cleared before first bit.
// RL5: Family code LSB first, then serial, gives CRC.
// RL6: Shifting received CRC too leaves zero if good.
// RL7: Storage is 32-byte pages plus a scratchpad page.
// RL8: Writes go to scratchpad, copy moves to memory.
// RL9: Three address registers: low, high, ending status.
// RL10: Target bits 4..0 pick byte within page.
// RL11: Status byte: offset, partial, overflow, authorization bits.
// RL12: Write scratchpad 0Fh: address low, high, then data.
// RL13: Data stored from target offset; ending offset recorded.
// RL14: Past offset 31 sets overflow, rest discarded.
// RL15: Stop mid-byte without overflow sets partial flag.
// RL16: Read scratchpad AAh returns address, status, then data.
// RL17: Copy 55h needs three bytes matching address registers.
// RL18: Authorization flag cleared only by new write.
// RL19: Read memory F0h takes address, streams to end.
// RL20: Write scratchpad clears overflow and partial flags.
// RL21: Addresses past last page lie outside memory.
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

// Register byte offsets
`define SPM_ADR_CTRL      8'h00
`define SPM_ADR_TXD       8'h04
`define SPM_ADR_RXD       8'h08
`define SPM_ADR_STAT      8'h0C
`define SPM_ADR_CRC       8'h10
`define SPM_ADR_TA_LOW    8'h14
`define SPM_ADR_TA_HIGH   8'h18
`define SPM_ADR_ES        8'h1C

// Control bits, each a one-shot on write
`define SPM_CTRL_RESET    0
`define SPM_CTRL_TX       1
`define SPM_CTRL_RX       2
`define SPM_CTRL_CRC_CLR  3
`define SPM_CTRL_ROM_DONE 4

// Status bits
`define SPM_ST_BUSY       0
`define SPM_ST_PRESENCE   1
`define SPM_ST_SELECTED   2
`define SPM_ST_CRC_ZERO   3
`define SPM_ST_REFUSED    4
`define SPM_ST_AUTH_BAD   5

// Ending-offset/status field positions
`define SPM_ES_OFS_MSB    4
`define SPM_ES_PF_BIT     5
`define SPM_ES_OF_BIT     6
`define SPM_ES_AA_BIT     7

// Command codes
`define SPM_ROM_SKIP      8'hCC
`define SPM_CMD_WR_SP     8'h0F
`define SPM_CMD_RD_SP     8'hAA
`define SPM_CMD_COPY      8'h55
`define SPM_CMD_RD_MEM    8'hF0
`define SPM_RX_FILL       8'hFF

// CRC-8, reflected form of x^8+x^5+x^4+1
`define SPM_CRC_POLY      8'h8C
`define SPM_CRC_INIT      8'h00

// Timing in microseconds and derived cycle counts
`define SPM_CLK_MHZ       100
`define SPM_T_RST_LOW_US  480
`define SPM_T_PRES_SMP_US 550
`define SPM_T_RST_END_US  960
`define SPM_T_SLOT_US     65
`define SPM_T_LOW1_US     6
`define SPM_T_LOW0_US     60
`define SPM_T_SMP_US      15
`define SPM_CNT_RST_LOW   (`SPM_T_RST_LOW_US * `SPM_CLK_MHZ)
`define SPM_CNT_PRES_SMP  (`SPM_T_PRES_SMP_US * `SPM_CLK_MHZ)
`define SPM_CNT_RST_END   (`SPM_T_RST_END_US * `SPM_CLK_MHZ)
`define SPM_CNT_SLOT      (`SPM_T_SLOT_US * `SPM_CLK_MHZ)
`define SPM_CNT_LOW1      (`SPM_T_LOW1_US * `SPM_CLK_MHZ)
`define SPM_CNT_LOW0      (`SPM_T_LOW0_US * `SPM_CLK_MHZ)
`define SPM_CNT_SMP       (`SPM_T_SMP_US * `SPM_CLK_MHZ)
`define SPM_CNT_W         17

`endif

// [design/spm_pkg.sv]
/*
 * Types shared by the scratchpad memory controller modules.
 * Assumes spm_map.svh is compiled alongside.
 */
package spm_pkg;
    typedef enum logic [1:0] {
        SPM_WIRE_IDLE,
        SPM_WIRE_RESET,
        SPM_WIRE_SLOT
    } spm_wire_e;

    typedef enum logic [2:0] {
        SPM_PH_NONE,
        SPM_PH_ROM,
        SPM_PH_ROMDATA,
        SPM_PH_MEM,
        SPM_PH_DATA
    } spm_phase_e;

    typedef logic [7:0] spm_byte_t;
endpackage

// [dv/spm_ctrl_checker.sv]
/* Port assertions for the single-wire scratchpad memory controller.
   Assumes binding to spm_ctrl and taking its timing parameters. */
`timescale 1ns/10ps
`include "spm_map.svh"
module spm_ctrl_checker #(
    parameter logic [`SPM_CNT_W-1:0] P_RST_LOW = 17'd40,
    parameter logic [`SPM_CNT_W-1:0] P_SLOT    = 17'd20,
    parameter logic [`SPM_CNT_W-1:0] P_LOW1    = 17'd2,
    parameter logic [`SPM_CNT_W-1:0] P_LOW0    = 17'd15
)(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Wire
    input wire logic        dq_out,
    input wire logic        dq_oe_b
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [`SPM_CNT_W-1:0] low_ff;
    logic [`SPM_CNT_W-1:0] gap_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) low_ff <= '0;
        else low_ff <= dq_oe_b ? '0 : low_ff + 1'b1;
    end
    // Saturates so a long idle never wraps into a false short gap
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) gap_ff <= '1;
        else if ($fell(dq_oe_b)) gap_ff <= `SPM_CNT_W'(1);
        else if (gap_ff != '1) gap_ff <= gap_ff + 1'b1;
    end

    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && $past(wb_adr_i) > 8'h1F
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without a read");
    chk_wire_drive: assert property (dq_out == 1'b0)
        else $error("wire driven high");
    chk_low_width: assert property ($rose(dq_oe_b) |-> low_ff == P_LOW1
        || low_ff == P_LOW0 || low_ff == P_RST_LOW) else $error("bad low width");
    chk_slot_spacing: assert property ($fell(dq_oe_b) |-> gap_ff >= P_SLOT)
        else $error("slots too close");
    chk_low_bounded: assert property (!dq_oe_b |-> low_ff < P_RST_LOW)
        else $error("wire held low too long");
endmodule // spm_ctrl_checker

bind spm_ctrl spm_ctrl_checker #(.P_RST_LOW(P_RST_LOW), .P_SLOT(P_SLOT), .P_LOW1(P_LOW1),
    .P_LOW0(P_LOW0)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dq_out(dq_out), .dq_oe_b(dq_oe_b));

// [dv/spm_ctrl_tb.sv]
/* Self-checking bench: Wishbone tasks drive the controller, a tag model sits on the wire.
   Assumes shortened slot timing so the run stays short. */
`timescale 1ns/10ps
module spm_ctrl_tb;
    logic        sys_clk  = 1'b0;
    logic        rst_b    = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        dq_out;
    logic        dq_oe_b;
    logic        dev_rel;
    logic [31:0] rd;
    int          bad_count;
    int          check_count;
    localparam logic [16:0] T_RLO = 17'd40, T_PSM = 17'd45, T_END = 17'd80, T_SLT = 17'd20;
    localparam logic [16:0] T_LO1 = 17'd2, T_LO0 = 17'd15, T_SMP = 17'd5;
    wire         dq = (dq_oe_b | dq_out) & dev_rel;

    initial forever #5 sys_clk = ~sys_clk;

    spm_ctrl #(.P_RST_LOW(T_RLO), .P_PRES_SMP(T_PSM), .P_RST_END(T_END), .P_SLOT(T_SLT),
               .P_LOW1(T_LO1), .P_LOW0(T_LO0), .P_SMP(T_SMP)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_in(dq), .dq_out(dq_out),
        .dq_oe_b(dq_oe_b));
    spm_dev_model u_dev (.sys_clk(sys_clk), .dq(dq), .dq_rel(dev_rel));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            complete_run();
        end
    endtask
    // One-shot control write, then poll busy
    task automatic go(input logic [7:0] c);
        int n;
        wb(1'b1, 8'h00, {24'h0, c});
        n = 0;
        do begin
            wb(1'b0, 8'h0C, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic tx(input logic [7:0] b);
        wb(1'b1, 8'h04, {24'h0, b});
        go(8'h02);
    endtask
    task automatic rx(input logic [7:0] e);
        go(8'h04);
        wb(1'b0, 8'h08, 32'h0);
        chk("rxd", rd, {24'h0, e});
    endtask
    task automatic send(input logic [7:0] s[$]);
        go(8'h01);
        foreach (s[i]) tx(s[i]);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask

    task automatic t_refuse;
        tx(8'h33);
        wb_sel_i <= 4'hE;
        wb(1'b1, 8'h04, 32'h5A);
        wb_sel_i <= 4'hF;
        rdchk("sel gate", 8'h04, 32'hFF, 32'h33);
        rdchk("refused", 8'h0C, 32'h10, 32'h10);
        wb(1'b1, 8'h0C, 32'h10);
        rdchk("refused clr", 8'h0C, 32'h10, 32'h0);
        rdchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        $display("t_refuse done");
    endtask
    task automatic t_crc;
        logic [7:0] c;
        logic [7:0] b;
        c = 8'h00;
        go(8'h01);
        rdchk("presence", 8'h0C, 32'h2, 32'h2);
        go(8'h08);
        for (int i = 0; i < 7; i++) begin
            b = 8'h29 + 8'(i * 37);
            tx(b);
            for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ b[k]) ? 8'h8C : 8'h00);
        end
        rdchk("crc", 8'h10, 32'hFF, {24'h0, c});
        tx(c);
        rdchk("crc zero", 8'h0C, 32'h8, 32'h8);
        $display("t_crc done");
    endtask
    // Start near page end so the third data byte overflows
    task automatic t_write;
        send('{8'hCC, 8'h0F, 8'h1E, 8'h00, 8'hA5, 8'h5A, 8'h77});
        rdchk("ta low", 8'h14, 32'hFF, 32'h1E);
        rdchk("ta high", 8'h18, 32'hFF, 32'h00);
        rdchk("selected", 8'h0C, 32'h4, 32'h4);
        send('{8'hCC, 8'hAA});
        rx(8'h1E);
        rx(8'h00);
        rx(8'h5F);
        rx(8'hA5);
        rx(8'h5A);
        rx(8'hFF);
        rdchk("es shadow", 8'h1C, 32'hFF, 32'h5F);
        $display("t_write done");
    endtask
    task automatic t_copy;
        send('{8'hCC, 8'h55, 8'h1E, 8'h00, 8'h5E});
        rdchk("auth bad", 8'h0C, 32'h20, 32'h20);
        wb(1'b1, 8'h0C, 32'h20);
        send('{8'hCC, 8'h55, 8'h1E, 8'h00, 8'h5F});
        rdchk("auth ok", 8'h0C, 32'h20, 32'h0);
        send('{8'hCC, 8'hAA});
        rx(8'h1E);
        rx(8'h00);
        rx(8'hDF);
        send('{8'hCC, 8'h0F, 8'h00, 8'h00, 8'h11});
        send('{8'hCC, 8'hAA});
        rx(8'h00);
        rx(8'h00);
        rx(8'h00);
        rx(8'h11);
        send('{8'hCC, 8'hF0, 8'h80, 8'h00});
        rx(8'hFF);
        rdchk("rm ta", 8'h14, 32'hFF, 32'h80);
        $display("t_copy done");
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_refuse();
        t_crc();
        t_write();
        t_copy();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end
endmodule // spm_ctrl_tb

// [dv/spm_dev_model.sv]
/* Behavioural scratchpad tag on the single wire; clocked only to keep time.
   Assumes the bench's short slot timing and a pull-up on the wire. */
`timescale 1ns/10ps
module spm_dev_model (
    // Time base
    input  wire logic sys_clk,
    // Wire level in, release out
    input  wire logic dq,
    output logic      dq_rel
);
    logic [7:0] sp [32];
    logic [7:0] ta_low  = 8'h00;
    logic [7:0] ta_high = 8'h00;
    logic [7:0] es      = 8'h00;
    logic [7:0] cmd     = 8'h00;
    logic [7:0] rx_sr   = 8'h00;
    logic [7:0] tx_sr   = 8'hFF;
    logic       w_q     = 1'b1;
    logic       sel     = 1'b0;
    logic       own     = 1'b0;
    logic       ok      = 1'b0;
    int         lcnt, bitn, idx, pres, drv;

    assign dq_rel = !(pres > 0 && pres <= 12) && drv == 0;

    task automatic take(input logic [7:0] b);
        int o;
        o = int'(ta_low[4:0]) + idx - 4;
        if (idx == 0) begin
            sel = (b == 8'hCC);
        end else if (idx == 1 && sel) begin
            cmd = b;
            ok = 1'b1;
            tx_sr = ta_low;
        end else if (sel && cmd == 8'h0F) begin
            if (idx == 2) begin
                ta_low = b;
                es = 8'h00;
            end else if (idx == 3) begin
                ta_high = b;
            end else if (o > 31) begin
                es[6] = 1'b1;
            end else begin
                sp[o] = b;
                es[4:0] = 5'(o);
            end
        end else if (sel && cmd == 8'hAA) begin
            tx_sr = idx == 2 ? ta_high : idx == 3 ? es : o < 32 ? sp[o] : 8'hFF;
        end else if (sel && cmd == 8'hF0) begin
            tx_sr = 8'hFF;
        end else if (sel && cmd == 8'h55 && idx < 5) begin
            ok = ok && b == (idx == 2 ? ta_low : idx == 3 ? ta_high : es);
            if (idx == 4 && ok) es[7] = 1'b1;
        end
        idx++;
    endtask

    always @(posedge sys_clk) begin
        if (drv > 0) drv--;
        if (pres > 0) pres--;
        if (!dq) begin
            lcnt++;
        end else if (!w_q) begin
            if (own) begin
                own = 1'b0;
            end else if (lcnt >= 30) begin
                if (sel && cmd == 8'h0F && bitn != 0 && !es[6]) es[5] = 1'b1;
                pres = 14;
                own = 1'b1;
                idx = 0;
                bitn = 0;
                sel = 1'b0;
            end else begin
                rx_sr = {lcnt < 8, rx_sr[7:1]};
                tx_sr = {1'b1, tx_sr[7:1]};
                bitn++;
                if (bitn == 8) begin
                    bitn = 0;
                    take(rx_sr);
                end
            end
            lcnt = 0;
        end
        if (w_q && !dq && sel && cmd == 8'hAA && idx > 1 && !tx_sr[0]) drv = 10;
        w_q = dq;
    end
endmodule // spm_dev_model
